/* hw/tcb_transfer_ctrl.sv */
// transfer controller: descriptor driven block and chain transfer engine
`timescale 1ns/100ps
`default_nettype none
// Function
// [RQ1] block mode moves whole block per activation
// [RQ2] block end restores unit count, area address
// [RQ3] block count 1..65536, interrupt at end
// [RQ4] count a high reload, low units, b blocks
// [RQ5] chain bit runs several descriptors per request
// [RQ6] vector gives start, descriptors read consecutively
// [RQ7] chained transfers raise nothing, flag untouched
// [RQ8] interrupt at count end or per-transfer bit
// [RQ9] raised interrupts pass mask and priority
// [RQ10] soft end keeps bit, raises end interrupt
// [RQ11] no soft end interrupt while waiting, running
// [RQ12] software clears soft bit in handler
// [RQ13] quiet soft end clears the soft bit
// [RQ14] vector, six descriptor accesses, three internal
// [RQ15] state cost follows bus width, target
// [RQ16] total states summed over chained transfers
// [RQ17] interrupt end clears source enable, raises
// [RQ18] software prepares descriptors, vector, enables
// [RQ19] software checks, writes, verifies soft vector
// [RQ20] zero counts mean 65536 blocks, 256 units
// [RQ21] updated descriptor written back each transfer
module tcb_transfer_ctrl
    import tcb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    tcb_if.ctl lnk,
    output logic busy
);
    tcb_state_t st_q;
    logic ack;
    logic last_w;
    logic blk;
    logic wsz;
    logic done;
    logic [7:0] unit_n;
    logic [15:0] blk_n;
    logic [15:0] cnt_n;
    logic [AW-1:0] src_n;
    logic [AW-1:0] dst_n;
    logic [1:0] idx_q;
    logic [1:0] iop_q;
    logic [AW-1:0] ptr_q;
    logic [AW-1:0] src_q;
    logic [AW-1:0] dst_q;
    logic [AW-1:0] src0_q;
    logic [AW-1:0] dst0_q;
    logic [7:0] ma_q;
    logic [7:0] mb_q;
    logic [15:0] cnta_q;
    logic [15:0] cntb_q;
    logic [15:0] run_q;
    logic [15:0] exec_q;
    logic [31:0] data_q;
    logic end_q;

    function automatic logic [AW-1:0] step(
        input logic [AW-1:0] a,
        input logic [1:0] m,
        input logic w
    );
        logic [AW-1:0] d;
        d = {{(AW-2){1'b0}}, w, ~w};
        if (m == AM_INC) begin
            step = a + d;
        end else if (m == AM_DEC) begin
            step = a - d;
        end else begin
            step = a;
        end
    endfunction

    assign ack = lnk.mem_ack;
    assign last_w = (idx_q == DESC_LAST);
    assign blk = (ma_q[MA_MD +: 2] == MD_BLOCK);
    assign wsz = ma_q[MA_SZ];
    assign src_n = step(src_q, ma_q[MA_SM +: 2], wsz);
    assign dst_n = step(dst_q, ma_q[MA_DM +: 2], wsz);
    // wrap from zero gives 256 units and 65536 blocks
    assign unit_n = cnta_q[7:0] - 8'h01; // [RQ20]
    assign blk_n = cntb_q - 16'h0001; // [RQ20]
    assign cnt_n = cnta_q - 16'h0001;
    // internal operations run once, after the last descriptor
    assign done = (st_q == S_INT) && (iop_q == INT_LAST); // [RQ14]
    assign busy = (st_q != S_IDLE);
    assign lnk.act_busy = busy;
    assign lnk.act_done = done;
    // only the unchained last descriptor reaches S_INT
    assign lnk.act_raise = done && (mb_q[MB_DIS] || end_q); // [RQ7] [RQ8] [RQ9] [RQ10] [RQ13] [RQ17]
    assign lnk.exec_states = exec_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
        end else begin
            unique case (st_q)
                S_IDLE: if (lnk.act_req) st_q <= S_VEC;
                S_VEC: if (ack) st_q <= S_DRD; // [RQ6]
                S_DRD: if (ack && last_w) st_q <= S_RD;
                S_RD: if (ack) st_q <= S_WR;
                S_WR: begin
                    if (ack) begin
                        st_q <= (blk && unit_n != 8'h00) ? S_RD : S_DWR; // [RQ1]
                    end
                end
                S_DWR: begin
                    if (ack && last_w) begin
                        st_q <= mb_q[MB_CHAIN] ? S_DRD : S_INT; // [RQ5] [RQ6]
                    end
                end
                S_INT: if (done) st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q <= 2'h0;
            iop_q <= 2'h0;
        end else begin
            if (ack && (st_q == S_DRD || st_q == S_DWR)) begin
                idx_q <= last_w ? 2'h0 : idx_q + 2'h1; // [RQ14]
            end
            iop_q <= (st_q == S_INT) ? iop_q + 2'h1 : 2'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_q <= VEC_BASE;
        end else if (st_q == S_IDLE && lnk.act_req) begin
            ptr_q <= VEC_BASE + {{(AW-9){1'b0}}, lnk.act_vec, 2'b00}; // [RQ6]
        end else if (st_q == S_VEC && ack) begin
            ptr_q <= lnk.mem_rdata[AW-1:0]; // [RQ6]
        end else if (st_q == S_DWR && ack && last_w) begin
            ptr_q <= ptr_q + DESC_STRIDE; // [RQ6]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ma_q <= 8'h00;
            mb_q <= 8'h00;
            src_q <= '0;
            dst_q <= '0;
            src0_q <= '0;
            dst0_q <= '0;
            cnta_q <= 16'h0000;
            cntb_q <= 16'h0000;
            end_q <= 1'b0;
        end else if (st_q == S_DRD && ack) begin
            if (idx_q == 2'h0) begin
                ma_q <= lnk.mem_rdata[31:24];
                src_q <= lnk.mem_rdata[AW-1:0];
                src0_q <= lnk.mem_rdata[AW-1:0];
            end else if (idx_q == 2'h1) begin
                mb_q <= lnk.mem_rdata[31:24];
                dst_q <= lnk.mem_rdata[AW-1:0];
                dst0_q <= lnk.mem_rdata[AW-1:0];
            end else begin
                cnta_q <= lnk.mem_rdata[31:16]; // [RQ4]
                cntb_q <= lnk.mem_rdata[15:0]; // [RQ4]
            end
        end else if (st_q == S_WR && ack) begin
            src_q <= src_n;
            dst_q <= dst_n;
            if (!blk) begin
                cnta_q <= cnt_n;
                end_q <= (cnt_n == 16'h0000);
            end else if (unit_n == 8'h00) begin
                // block done: block area and unit count return to start
                if (ma_q[MA_AREA]) begin
                    dst_q <= dst0_q; // [RQ2]
                end else begin
                    src_q <= src0_q; // [RQ2]
                end
                cnta_q[7:0] <= cnta_q[15:8]; // [RQ2] [RQ4]
                cntb_q <= blk_n; // [RQ4]
                end_q <= (blk_n == 16'h0000); // [RQ3]
            end else begin
                cnta_q[7:0] <= unit_n; // [RQ4]
                end_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= 32'h00000000;
        end else if (st_q == S_RD && ack) begin
            data_q <= lnk.mem_rdata;
        end
    end

    // state budget: every non-idle cycle of one activation is one state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 16'h0000;
            exec_q <= 16'h0000;
        end else begin
            run_q <= (st_q == S_IDLE) ? 16'h0000 : run_q + 16'h0001; // [RQ16]
            if (done) begin
                exec_q <= run_q + 16'h0001; // [RQ16]
            end
        end
    end

    always_comb begin
        lnk.mem_req = 1'b0;
        lnk.mem_we = 1'b0;
        lnk.mem_size = SZ_LONG;
        lnk.mem_addr = ptr_q;
        lnk.mem_wdata = data_q;
        unique case (st_q)
            S_IDLE, S_INT: begin
            end
            S_VEC: begin
                lnk.mem_req = 1'b1; // [RQ14]
            end
            S_DRD: begin
                lnk.mem_req = 1'b1; // [RQ14]
                lnk.mem_addr = ptr_q + {{(AW-4){1'b0}}, idx_q, 2'b00};
            end
            S_RD: begin
                lnk.mem_req = 1'b1; // [RQ1] [RQ15]
                lnk.mem_size = wsz ? SZ_WORD : SZ_BYTE;
                lnk.mem_addr = src_q;
            end
            S_WR: begin
                lnk.mem_req = 1'b1; // [RQ15]
                lnk.mem_we = 1'b1;
                lnk.mem_size = wsz ? SZ_WORD : SZ_BYTE;
                lnk.mem_addr = dst_q;
            end
            S_DWR: begin
                lnk.mem_req = 1'b1;
                lnk.mem_we = 1'b1;
                lnk.mem_addr = ptr_q + {{(AW-4){1'b0}}, idx_q, 2'b00};
                if (idx_q == 2'h0) begin
                    lnk.mem_wdata = {ma_q, src_q}; // [RQ21]
                end else if (idx_q == 2'h1) begin
                    lnk.mem_wdata = {mb_q, dst_q}; // [RQ21]
                end else begin
                    lnk.mem_wdata = {cnta_q, cntb_q}; // [RQ21]
                end
            end
        endcase
    end
endmodule
`default_nettype wire

/* hw/tcb_pkg.sv */
// shared constants and types for the transfer controller and its system end
package tcb_pkg;
    localparam int NSRC = 4;
    localparam int NIRQ = NSRC + 1;
    localparam int AW = 24;
    localparam int RAM_WORDS = 256;
    // vector table base and first hardware source vector
    localparam logic [AW-1:0] VEC_BASE = 24'h000000;
    localparam logic [6:0] VEC_SRC0 = 7'h10;
    // bus access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // mode word a fields
    localparam int MA_SM = 6;
    localparam int MA_DM = 4;
    localparam int MA_MD = 2;
    localparam int MA_AREA = 1;
    localparam int MA_SZ = 0;
    localparam logic [1:0] AM_INC = 2'h2;
    localparam logic [1:0] AM_DEC = 2'h3;
    localparam logic [1:0] MD_BLOCK = 2'h2;
    // mode word b fields
    localparam int MB_CHAIN = 7;
    localparam int MB_DIS = 6;
    // descriptor is three long words; stride to the next one
    localparam logic [1:0] DESC_LAST = 2'h2;
    localparam logic [AW-1:0] DESC_STRIDE = 24'h00000c;
    localparam logic [1:0] INT_LAST = 2'h2;
    // bus latencies in cycles
    localparam logic [11:0] LAT_INT = 12'h001;
    localparam logic [11:0] LAT_EXT = 12'h003;
    localparam int EXT_BIT = 23;
    // register offsets of the system end
    localparam logic [11:0] R_ACT_EN = 12'h000;
    localparam logic [11:0] R_SOFT = 12'h004;
    localparam logic [11:0] R_PEND = 12'h008;
    localparam logic [11:0] R_IEN = 12'h00c;
    localparam logic [11:0] R_PRIO = 12'h010;
    localparam logic [11:0] R_MASK = 12'h014;
    localparam logic [11:0] R_EXT = 12'h018;
    localparam logic [11:0] R_STAT = 12'h01c;
    localparam logic [1:0] RAM_SEL = 2'h1;
    localparam int SOFT_BIT = 7;
    localparam logic [31:0] REG_RST = 32'h00000000;

    typedef enum logic [2:0] {
        S_IDLE, S_VEC, S_DRD, S_RD, S_WR, S_DWR, S_INT
    } tcb_state_t;
endpackage

/* hw/tcb_if.sv */
// link between the transfer controller and the system end
`timescale 1ns/100ps
`default_nettype none
interface tcb_if;
    import tcb_pkg::*;
    logic act_req;
    logic [6:0] act_vec;
    logic act_busy;
    logic act_done;
    logic act_raise;
    logic mem_req;
    logic mem_we;
    logic [1:0] mem_size;
    logic [AW-1:0] mem_addr;
    logic [31:0] mem_wdata;
    logic mem_ack;
    logic [31:0] mem_rdata;
    logic [15:0] exec_states;
    modport ctl (
        input act_req, act_vec, mem_ack, mem_rdata,
        output act_busy, act_done, act_raise, mem_req, mem_we, mem_size,
        output mem_addr, mem_wdata, exec_states
    );
    modport sys (
        output act_req, act_vec, mem_ack, mem_rdata,
        input act_busy, act_done, act_raise, mem_req, mem_we, mem_size,
        input mem_addr, mem_wdata, exec_states
    );
endinterface
`default_nettype wire

/* hw/tcb_sys_end.sv */
// system end: ahb registers, interrupt control, on-chip ram and bus timing
`timescale 1ns/100ps
`default_nettype none
module tcb_sys_end
    import tcb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NSRC-1:0] src_event,
    output logic cpu_irq,
    output logic [2:0] cpu_irq_id,
    tcb_if.sys lnk
);
    logic [31:0] ram [RAM_WORDS];
    logic act_q, wr_q, wen;
    logic [11:0] a_q;
    logic [NSRC-1:0] act_en_q, pend_q, ien_q, oh, w1c;
    logic [2*NIRQ-1:0] prio_q;
    logic [1:0] mask_q, best_p;
    logic [7:0] wait_q;
    logic bus8_q, soft_q, served_q, hw_done, sw_done, cand_ok, best_ok;
    logic [6:0] svec_q;
    logic [2:0] svc_q, cand_id, best_id;
    logic [NIRQ-1:0] want;
    logic [11:0] lat_q, need, base;
    logic [31:0] rw;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wen = act_q && wr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= 12'h000;
        end else if (hready) begin
            act_q <= hsel && htrans[1];
            wr_q <= hwrite;
            a_q <= haddr[11:0];
        end
    end

    assign hw_done = lnk.act_done && !svc_q[2];
    assign sw_done = lnk.act_done && svc_q[2];
    assign oh = hw_done ? (NSRC'(1) << svc_q[1:0]) : '0;
    assign w1c = (wen && a_q == R_PEND) ? hwdata[NSRC-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_en_q <= REG_RST[NSRC-1:0];
            pend_q <= REG_RST[NSRC-1:0];
            ien_q <= REG_RST[NSRC-1:0];
            prio_q <= REG_RST[2*NIRQ-1:0];
            mask_q <= REG_RST[1:0];
            wait_q <= REG_RST[7:0];
            bus8_q <= 1'b0;
        end else begin
            // a new event wins over any clear in the same cycle
            pend_q <= (pend_q & ~w1c & ~(lnk.act_raise ? '0 : oh)) | src_event; // [RQ7]
            if (wen && a_q == R_ACT_EN) begin
                act_en_q <= hwdata[NSRC-1:0]; // [RQ18]
            end else if (lnk.act_raise) begin
                act_en_q <= act_en_q & ~oh; // [RQ17]
            end
            if (wen && a_q == R_IEN) ien_q <= hwdata[NSRC-1:0];
            if (wen && a_q == R_PRIO) prio_q <= hwdata[2*NIRQ-1:0];
            if (wen && a_q == R_MASK) mask_q <= hwdata[1:0];
            if (wen && a_q == R_EXT) begin
                wait_q <= hwdata[7:0];
                bus8_q <= hwdata[8];
            end
        end
    end

    // soft vector: a set while the bit is already 1 is ignored, so a
    // read-back tells software whether its own request went in
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_q <= 1'b0;
            served_q <= 1'b0;
            svec_q <= 7'h00;
        end else begin
            if (sw_done && lnk.act_raise) begin
                served_q <= 1'b1; // [RQ10]
            end else if (sw_done) begin
                soft_q <= 1'b0; // [RQ13]
            end
            if (wen && a_q == R_SOFT) begin
                if (!hwdata[SOFT_BIT]) begin
                    soft_q <= 1'b0; // [RQ12]
                    served_q <= 1'b0;
                end else if (!soft_q) begin
                    soft_q <= 1'b1; // [RQ19]
                    served_q <= 1'b0;
                    svec_q <= hwdata[6:0];
                end
            end
        end
    end

    always_comb begin
        cand_ok = soft_q && !served_q;
        cand_id = 3'(NSRC);
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend_q[i] && act_en_q[i]) begin
                cand_ok = 1'b1;
                cand_id = 3'(i);
            end
        end
    end

    assign lnk.act_req = cand_ok && !lnk.act_busy;
    assign lnk.act_vec = cand_id[2] ? svec_q : VEC_SRC0 + 7'(cand_id);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_q <= 3'h0;
        end else if (lnk.act_req) begin
            svc_q <= cand_id;
        end
    end

    // soft end shows only once the device has reported it
    assign want = {soft_q && served_q, pend_q & ien_q & ~act_en_q}; // [RQ11]

    always_comb begin
        best_ok = 1'b0;
        best_id = 3'h0;
        best_p = mask_q;
        for (int i = 0; i < NIRQ; i++) begin
            if (want[i] && prio_q[2*i +: 2] > best_p) begin
                best_ok = 1'b1; // [RQ9]
                best_id = 3'(i);
                best_p = prio_q[2*i +: 2];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_irq <= 1'b0;
            cpu_irq_id <= 3'h0;
        end else begin
            cpu_irq <= best_ok;
            cpu_irq_id <= best_id;
        end
    end

    // external region: 3+m per 16-bit access, doubled on the 8-bit bus
    always_comb begin
        base = LAT_EXT + {4'h0, wait_q};
        need = LAT_INT;
        if (lnk.mem_addr[EXT_BIT]) begin
            unique case (lnk.mem_size)
                SZ_BYTE: need = base; // [RQ15]
                SZ_WORD: need = bus8_q ? base << 1 : base; // [RQ15]
                default: need = bus8_q ? base << 2 : base << 1; // [RQ15]
            endcase
        end
    end

    assign lnk.mem_ack = lnk.mem_req && (lat_q == need - LAT_INT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lat_q <= 12'h000;
        end else begin
            lat_q <= (lnk.mem_req && !lnk.mem_ack) ? lat_q + 12'h001 : 12'h000;
        end
    end

    assign rw = ram[lnk.mem_addr[9:2]];

    always_comb begin
        unique case (lnk.mem_size)
            SZ_BYTE: lnk.mem_rdata = {24'h000000, rw[8*lnk.mem_addr[1:0] +: 8]};
            SZ_WORD: lnk.mem_rdata = {16'h0000, rw[16*lnk.mem_addr[1] +: 16]};
            default: lnk.mem_rdata = rw;
        endcase
    end

    // a bus write lands after the device write, so it wins on a clash
    always_ff @(posedge hclk) begin
        if (lnk.mem_ack && lnk.mem_we) begin
            unique case (lnk.mem_size)
                SZ_BYTE: ram[lnk.mem_addr[9:2]][8*lnk.mem_addr[1:0] +: 8] <= lnk.mem_wdata[7:0];
                SZ_WORD: ram[lnk.mem_addr[9:2]][16*lnk.mem_addr[1] +: 16] <= lnk.mem_wdata[15:0];
                default: ram[lnk.mem_addr[9:2]] <= lnk.mem_wdata;
            endcase
        end
        if (wen && a_q[11:10] == RAM_SEL) begin
            ram[a_q[9:2]] <= hwdata; // [RQ18]
        end
    end

    always_comb begin
        hrdata = 32'h00000000;
        if (a_q[11:10] == RAM_SEL) begin
            hrdata = ram[a_q[9:2]];
        end else begin
            unique case (a_q)
                R_ACT_EN: hrdata = {{(32-NSRC){1'b0}}, act_en_q};
                R_SOFT: hrdata = {24'h000000, soft_q, svec_q};
                R_PEND: hrdata = {{(32-NSRC){1'b0}}, pend_q};
                R_IEN: hrdata = {{(32-NSRC){1'b0}}, ien_q};
                R_PRIO: hrdata = {{(32-2*NIRQ){1'b0}}, prio_q};
                R_MASK: hrdata = {30'h00000000, mask_q};
                R_EXT: hrdata = {23'h000000, bus8_q, wait_q};
                R_STAT: hrdata = {15'h0000, lnk.act_busy, lnk.exec_states};
                default: hrdata = 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

/* bench/tcb_sva.sv */
// protocol checks on the link between the controller and the system end
`timescale 1ns/100ps
`default_nettype none
module tcb_sva
    import tcb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic act_req,
    input wire logic [6:0] act_vec,
    input wire logic act_busy,
    input wire logic act_done,
    input wire logic act_raise,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [AW-1:0] mem_addr,
    input wire logic mem_ack
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence take_s;
        act_req && !act_busy;
    endsequence
    sequence vec_rd_s;
        mem_req && !mem_we && mem_addr == VEC_BASE + {15'h0, $past(act_vec), 2'h0};
    endsequence
    // the shortest activation is one vector read, one descriptor and three internal cycles
    take_busy_a: assert property (take_s |=> act_busy) else $error("busy missing");
    vec_first_a: assert property (take_s |=> vec_rd_s) else $error("bad vector read");
    act_span_a: assert property (take_s |-> ##[12:1000] act_done)
        else $error("activation too short or hung");
    done_end_a: assert property (act_done |=> !act_done && !act_busy)
        else $error("done not a closing pulse");
    done_busy_a: assert property (act_done |-> act_busy) else $error("done while idle");
    raise_done_a: assert property (act_raise |-> act_done) else $error("stray raise");
    req_hold_a: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("access dropped");
    int_ack_a: assert property (mem_req && !mem_addr[EXT_BIT] |-> mem_ack)
        else $error("internal access slow");
    idle_quiet_a: assert property (!act_busy |-> !mem_req)
        else $error("access while idle");
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench joining the controller and the system end
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tcb_pkg::*;
    logic hclk, hresetn, hwrite, hready, hresp, cpu_irq, busy;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [NSRC-1:0] src_event;
    logic [2:0] cpu_irq_id;
    int miscompares, n_checks, cyc;
    tcb_if link();
    tcb_transfer_ctrl tcb_transfer_ctrl_i (.hclk(hclk), .hresetn(hresetn), .lnk(link),
        .busy(busy));
    tcb_sys_end tcb_sys_end_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .src_event(src_event),
        .cpu_irq(cpu_irq), .cpu_irq_id(cpu_irq_id), .lnk(link));
    tcb_sva tcb_sva_i (.hclk(hclk), .hresetn(hresetn), .act_req(link.act_req),
        .act_vec(link.act_vec), .act_busy(link.act_busy), .act_done(link.act_done),
        .act_raise(link.act_raise), .mem_req(link.mem_req), .mem_we(link.mem_we),
        .mem_addr(link.mem_addr), .mem_ack(link.mem_ack));

    initial begin
        hclk = 0;
        forever #50 hclk = ~hclk;
    end

    // generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task tally_and_finish();
        if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask

    // ready and read data are taken at the rising edge, before it updates any flop
    task wait_rdy();
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        chk({31'h0, hresp}, 32'h0);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task wm(input logic [11:0] dev, input logic [31:0] d);
        wr(12'h400 + dev, d);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        ahb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask

    task irq(input logic [3:0] e);
        @(negedge hclk);
        chk({28'h0, cpu_irq, cpu_irq ? cpu_irq_id : 3'h0}, {28'h0, e});
        @(posedge hclk);
    endtask

    task wait_done();
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge hclk);
            if (link.act_busy === 1'b1) chk({31'h0, cpu_irq}, 32'h0);
            if (link.act_done === 1'b1) break;
        end
        chk({31'h0, link.act_done}, 32'h1);
        chk({31'h0, busy}, 32'h1);
        repeat (3) @(posedge hclk);
        chk({31'h0, busy}, 32'h0);
    endtask

    task reset_regs();
        for (int o = 0; o < 32; o += 4) rdc(o[11:0], REG_RST, 32'hffffffff);
        rdc(12'h0f0, 32'h0, 32'hffffffff);
    endtask

    // two chained descriptors; the first ends its count yet must stay silent,
    // the second reads a word, counting down, from the slow external region
    task chain_hw();
        wm(12'h044, 32'h140);
        wm(12'h140, 32'h80000210);
        wm(12'h144, 32'hc0000310);
        wm(12'h148, 32'h00010000);
        wm(12'h14c, 32'hc1800220);
        wm(12'h150, 32'h40000320);
        wm(12'h154, 32'h00030000);
        wr(R_EXT, 32'h102);
        wr(R_ACT_EN, 32'h2);
        wr(R_IEN, 32'h2);
        wr(R_PRIO, 32'h30c);
        src_event <= 4'h2;
        @(posedge hclk);
        src_event <= 4'h0;
        wait_done();
        // vector 1, descriptors 8 and 3+(6+2*2)+1+3 on the 8-bit bus, internal 3
        chk({16'h0, link.exec_states}, 32'd29);
        rdc(12'h540, 32'h80000211, 32'hffffffff);
        rdc(12'h548, 32'h0, 32'hffff0000);
        rdc(12'h54c, 32'hc180021e, 32'hffffffff);
        rdc(12'h554, 32'h00020000, 32'hffff0000);
        rdc(R_ACT_EN, 32'h0, 32'hf);
        rdc(R_PEND, 32'h2, 32'hf);
        irq(4'h9);
        wr(R_MASK, 32'h3);
        @(posedge hclk);
        irq(4'h0);
        wr(R_MASK, 32'h0);
        wr(R_PEND, 32'h2);
        @(posedge hclk);
        irq(4'h0);
    endtask

    // a four-byte block into a fixed area, three times, by software start;
    // the third run starts from a zero block count, which must not end it
    task block_soft();
        wm(12'h080, 32'h100);
        wm(12'h100, 32'haa000200);
        wm(12'h104, 32'h00000300);
        wm(12'h108, 32'h04040002);
        wm(12'h200, 32'h03020100);
        wm(12'h204, 32'h07060504);
        wm(12'h208, 32'h0b0a0908);
        for (int k = 0; k < 3; k++) begin
            wr(R_SOFT, 32'ha0);
            rdc(R_SOFT, 32'ha0, 32'hff);
            wait_done();
            rdc(12'h700, 32'h03020100 + 32'h04040404 * k, 32'hffffffff);
            rdc(R_STAT, 32'd18, 32'h1ffff);
            rdc(12'h508, {16'h0404, 16'(1 - k)}, 32'hffffffff);
            rdc(12'h504, 32'h00000300, 32'hffffffff);
            rdc(12'h500, 32'haa000204 + 4 * k, 32'hffffffff);
            rdc(R_SOFT, k == 1 ? 32'h80 : 32'h0, 32'h80);
            irq(k == 1 ? 4'hc : 4'h0);
            if (k == 1) begin
                wr(R_SOFT, 32'h20);
                @(posedge hclk);
                irq(4'h0);
            end
        end
    endtask

    initial begin
        hresetn = 0;
        htrans = 0;
        hwrite = 0;
        haddr = 0;
        hwdata = 0;
        src_event = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        reset_regs();
        chain_hw();
        block_soft();
        tally_and_finish();
    end
endmodule
`default_nettype wire
